// File: logic/dcs_pkg.sv
// Constants and register map for the drive command and status register bank.
//
// Operation
// - Run-command bits b0-b11 drive inputs, reset zero.
// - Value 5 gives forward run plus high speed.
// - Bit functions follow assignments, never sequence start.
// - Network mode forces bit0 forward, bit1 reverse.
// - Enable bits b0-b11 hand control over, reset zero.
// - Enabled positions ignore terminal and fieldbus inputs.
// - Sequence start always comes from the terminals.
// - Register run control inactive in panel mode.
// - Refused writes store an access error code.
// - Failed parameter write stores number plus 8000h.
// - Other failed writes store ffffh; reset zero.
// - Error code held until software writes zero.
// - Status word follows present drive condition continuously.
// - Alarm value 16 to 20 stops the drive.
// - Other alarm values are invalid, no alarm.
// - Alarm disabled while sequence enable is zero.
// - Alarm code reported equals written value.
// - Display selection 40/41/42 shows monitors one-three.
// - Decimal field 00/01/10/11 gives 1/.1/.01/.001.
// - Decimal select bits outside fields are ignored.
`default_nettype none
package dcs_pkg;
   // Register byte offsets on the AXI4-Lite bus.
   localparam logic [7:0] OFS_RUN_CMD = 8'h00;
   localparam logic [7:0] OFS_RUN_ENA = 8'h04;
   localparam logic [7:0] OFS_ACC_ERR = 8'h08;
   localparam logic [7:0] OFS_STATUS  = 8'h0c;
   localparam logic [7:0] OFS_ALARM   = 8'h10;
   localparam logic [7:0] OFS_DEC_SEL = 8'h14;
   localparam logic [7:0] OFS_MON1    = 8'h18;
   localparam logic [7:0] OFS_MON2    = 8'h1c;
   localparam logic [7:0] OFS_MON3    = 8'h20;
   // Reset values.
   localparam logic [15:0] RST_RUN_CMD = 16'h0000;
   localparam logic [15:0] RST_RUN_ENA = 16'h0000;
   localparam logic [15:0] RST_ACC_ERR = 16'h0000;
   localparam logic [15:0] RST_WORD    = 16'h0000;
   // Error codes.
   localparam logic [15:0] ERR_PARAM_BASE = 16'h8000;
   localparam logic [15:0] ERR_OTHER      = 16'hffff;
   // User alarm window.
   localparam logic [15:0] ALARM_MIN = 16'h0010;
   localparam logic [15:0] ALARM_MAX = 16'h0014;
   // Input function codes; forward, reverse and no-function codes are plain defaults.
   localparam logic [7:0] FUNC_SEQ_START = 8'h32;
   localparam logic [7:0] FUNC_FORWARD   = 8'h3c;
   localparam logic [7:0] FUNC_REVERSE   = 8'h3d;
   localparam logic [7:0] FUNC_NONE      = 8'hff;
   // Display selection codes for the three user monitors.
   localparam logic [7:0] DISP_MON1 = 8'h28;
   localparam logic [7:0] DISP_MON2 = 8'h29;
   localparam logic [7:0] DISP_MON3 = 8'h2a;
   // Decimal point field positions.
   localparam int DP_POS_MON1 = 8;
   localparam int DP_POS_MON2 = 10;
   localparam int DP_POS_MON3 = 12;
   // Operation mode encoding.
   localparam logic [1:0] MODE_NET   = 2'h0;
   localparam logic [1:0] MODE_EXT   = 2'h1;
   localparam logic [1:0] MODE_PANEL = 2'h2;
   // AXI responses.
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : dcs_pkg
`default_nettype wire

// File: logic/dcs_input_route.sv
// Per-bit source and function routing for the drive input functions.
`timescale 1ns/10ps
`default_nettype none
module dcs_input_route #(
   parameter int N = 12
) (
   input  wire logic [N-1:0]   run_cmd,
   input  wire logic [N-1:0]   run_flags,
   input  wire logic [N-1:0]   run_ena,
   input  wire logic [N-1:0]   term_in,
   input  wire logic [N-1:0]   bus_in,
   input  wire logic [N*8-1:0] func_assign,
   input  wire logic           net_mode,
   input  wire logic           panel_mode,
   output logic      [N-1:0]   level,
   output logic      [N*8-1:0] func
);
   // One lane per input position; each lane picks its source and function code.
   for (genvar i = 0; i < N; i++) begin : g_lane
      wire       reg_ctl = run_ena[i] & ~panel_mode;
      wire [7:0] raw     = func_assign[i*8 +: 8];
      wire [7:0] net_fn  = (i == 0) ? dcs_pkg::FUNC_FORWARD : dcs_pkg::FUNC_REVERSE;
      // Enabled lanes take register bits; terminals and fieldbus are dropped.
      assign level[i] = reg_ctl ? (run_cmd[i] | run_flags[i]) : (term_in[i] | bus_in[i]);
      // Sequence start can never ride on a register-controlled lane.
      assign func[i*8 +: 8] = (i < 2 && net_mode) ? net_fn :
                              (reg_ctl && raw == dcs_pkg::FUNC_SEQ_START) ? dcs_pkg::FUNC_NONE :
                              raw;
   end
endmodule : dcs_input_route
`default_nettype wire

// File: logic/dcs_regs.sv
// AXI4-Lite register bank for drive run command, errors, alarm and user monitors.
//
// The AXI4-Lite slave port and the register addresses were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module dcs_regs #(
   parameter int N  = 12,
   parameter int AW = 8
) (
   input  wire logic           aclk,
   input  wire logic           aresetn,
   // AXI4-Lite slave.
   input  wire logic [AW-1:0]  awaddr,
   input  wire logic [2:0]     awprot,
   input  wire logic           awvalid,
   output logic                awready,
   input  wire logic [31:0]    wdata,
   input  wire logic [3:0]     wstrb,
   input  wire logic           wvalid,
   output logic                wready,
   output logic [1:0]          bresp,
   output logic                bvalid,
   input  wire logic           bready,
   input  wire logic [AW-1:0]  araddr,
   input  wire logic [2:0]     arprot,
   input  wire logic           arvalid,
   output logic                arready,
   output logic [31:0]         rdata,
   output logic [1:0]          rresp,
   output logic                rvalid,
   input  wire logic           rready,
   // Drive side.
   input  wire logic [1:0]     op_mode,
   input  wire logic [N-1:0]   run_command_flags,
   input  wire logic [N-1:0]   term_in,
   input  wire logic [N-1:0]   bus_in,
   input  wire logic [N*8-1:0] input_function_assignment,
   input  wire logic           sequence_start_input,
   input  wire logic [15:0]    drive_status_in,
   input  wire logic           param_err_pulse,
   input  wire logic [14:0]    param_err_num,
   input  wire logic           other_err_pulse,
   input  wire logic [7:0]     sequence_function_enable_param,
   input  wire logic [7:0]     monitor_display_selection,
   output logic [N-1:0]        drive_in_level,
   output logic [N*8-1:0]      drive_in_func,
   output logic                drive_seq_start,
   output logic                user_alarm,
   output logic [4:0]          user_alarm_code,
   output logic                panel_mon_valid,
   output logic [15:0]         panel_mon_value,
   output logic [1:0]          panel_mon_dp
);
   // Register state.
   logic [N-1:0]   run_cmd_q;
   logic [N-1:0]   run_ena_q;
   logic [15:0]    acc_err_q;
   logic [15:0]    status_q;
   logic [15:0]    alarm_q;
   logic [15:0]    dec_sel_q;
   logic [15:0]    mon_q [3];
   // Bus state.
   logic           awready_q;
   logic           wready_q;
   logic           bvalid_q;
   logic [1:0]     bresp_q;
   logic           arready_q;
   logic           rvalid_q;
   logic [31:0]    rdata_q;
   logic [1:0]     rresp_q;
   logic [AW-1:0]  waddr_q;
   logic [15:0]    wdata_q;
   logic [1:0]     wstrb_q;
   // Drive-side outputs.
   logic [N-1:0]   level_q;
   logic [N*8-1:0] func_q;
   logic           seq_q;
   logic           alarm_out_q;
   logic [4:0]     alarm_code_q;
   logic           mon_valid_q;
   logic [15:0]    mon_value_q;
   logic [1:0]     mon_dp_q;

   // Channel handshakes; address and data are accepted in either order.
   wire aw_hs   = awvalid & awready_q;
   wire w_hs    = wvalid & wready_q;
   wire aw_have = ~awready_q & ~bvalid_q;
   wire w_have  = ~wready_q & ~bvalid_q;
   wire do_wr   = aw_have & w_have;
   wire b_hs    = bvalid_q & bready;
   wire ar_hs   = arvalid & arready_q;
   wire r_hs    = rvalid_q & rready;

   // Write address decode; low two address bits are ignored.
   wire [AW-1:0] wa    = {waddr_q[AW-1:2], 2'b00};
   wire sel_run_cmd    = wa == AW'(dcs_pkg::OFS_RUN_CMD);
   wire sel_run_ena    = wa == AW'(dcs_pkg::OFS_RUN_ENA);
   wire sel_acc_err    = wa == AW'(dcs_pkg::OFS_ACC_ERR);
   wire sel_status     = wa == AW'(dcs_pkg::OFS_STATUS);
   wire sel_alarm      = wa == AW'(dcs_pkg::OFS_ALARM);
   wire sel_dec_sel    = wa == AW'(dcs_pkg::OFS_DEC_SEL);
   wire sel_mon1       = wa == AW'(dcs_pkg::OFS_MON1);
   wire sel_mon2       = wa == AW'(dcs_pkg::OFS_MON2);
   wire sel_mon3       = wa == AW'(dcs_pkg::OFS_MON3);
   wire w_mapped       = sel_run_cmd | sel_run_ena | sel_acc_err | sel_status | sel_alarm |
                         sel_dec_sel | sel_mon1 | sel_mon2 | sel_mon3;

   // Byte-lane merge helper; only the two low lanes hold register bits.
   function automatic logic [15:0] merge(input logic [15:0] old_v);
      logic [15:0] m;
      m = {{8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
      return (old_v & ~m) | (wdata_q & m);
   endfunction : merge

   // Continuous merges are spelled out: a function call here would only wake on its argument,
   // not on the held data or strobes, and would leave a stale value.
   wire [15:0] wr_mask   = {{8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
   wire [15:0] run_cmd_m = (16'(run_cmd_q) & ~wr_mask) | (wdata_q & wr_mask);
   wire [15:0] run_ena_m = (16'(run_ena_q) & ~wr_mask) | (wdata_q & wr_mask);
   wire [15:0] acc_err_m = (acc_err_q & ~wr_mask) | (wdata_q & wr_mask);

   // Read address decode and data select.
   wire [AW-1:0] ra = {araddr[AW-1:2], 2'b00};
   wire [15:0] rd_word =
      (ra == AW'(dcs_pkg::OFS_RUN_CMD)) ? 16'(run_cmd_q) :
      (ra == AW'(dcs_pkg::OFS_RUN_ENA)) ? 16'(run_ena_q) :
      (ra == AW'(dcs_pkg::OFS_ACC_ERR)) ? acc_err_q :
      (ra == AW'(dcs_pkg::OFS_STATUS))  ? status_q :
      (ra == AW'(dcs_pkg::OFS_ALARM))   ? alarm_q :
      (ra == AW'(dcs_pkg::OFS_DEC_SEL)) ? dec_sel_q :
      (ra == AW'(dcs_pkg::OFS_MON1))    ? mon_q[0] :
      (ra == AW'(dcs_pkg::OFS_MON2))    ? mon_q[1] :
      (ra == AW'(dcs_pkg::OFS_MON3))    ? mon_q[2] : 16'h0000;
   wire r_mapped = ra <= AW'(dcs_pkg::OFS_MON3);

   // Write address channel; ready drops while an address waits for its data or response.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         awready_q <= 1'b1;
         waddr_q   <= '0;
      end else if (aw_hs) begin
         awready_q <= 1'b0;
         waddr_q   <= awaddr;
      end else if (b_hs) begin
         awready_q <= 1'b1;
      end
   end

   // Write data channel, mirrored on the address channel.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wready_q <= 1'b1;
         wdata_q  <= 16'h0000;
         wstrb_q  <= 2'b00;
      end else if (w_hs) begin
         wready_q <= 1'b0;
         wdata_q  <= wdata[15:0];
         wstrb_q  <= wstrb[1:0];
      end else if (b_hs) begin
         wready_q <= 1'b1;
      end
   end

   // Write response one cycle after both halves are held.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid_q <= 1'b0;
         bresp_q  <= dcs_pkg::RESP_OKAY;
      end else if (do_wr) begin
         bvalid_q <= 1'b1;
         bresp_q  <= w_mapped ? dcs_pkg::RESP_OKAY : dcs_pkg::RESP_SLVERR;
      end else if (b_hs) begin
         bvalid_q <= 1'b0;
      end
   end

   // Read channel; one read under way at a time.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready_q <= 1'b1;
         rvalid_q  <= 1'b0;
         rdata_q   <= 32'h00000000;
         rresp_q   <= dcs_pkg::RESP_OKAY;
      end else if (ar_hs) begin
         arready_q <= 1'b0;
         rvalid_q  <= 1'b1;
         rdata_q   <= {16'h0000, rd_word};
         rresp_q   <= r_mapped ? dcs_pkg::RESP_OKAY : dcs_pkg::RESP_SLVERR;
      end else if (r_hs) begin
         arready_q <= 1'b1;
         rvalid_q  <= 1'b0;
      end
   end

   // Run command and enable words; registers stay writable in every mode.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         run_cmd_q <= N'(dcs_pkg::RST_RUN_CMD);
         run_ena_q <= N'(dcs_pkg::RST_RUN_ENA);
      end else if (do_wr) begin
         if (sel_run_cmd) run_cmd_q <= run_cmd_m[N-1:0];
         if (sel_run_ena) run_ena_q <= run_ena_m[N-1:0];
      end
   end

   // Access error code; a new error wins over a clearing write in the same cycle.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         acc_err_q <= dcs_pkg::RST_ACC_ERR;
      end else if (param_err_pulse) begin
         acc_err_q <= dcs_pkg::ERR_PARAM_BASE | {1'b0, param_err_num};
      end else if (other_err_pulse) begin
         acc_err_q <= dcs_pkg::ERR_OTHER;
      end else if (do_wr && sel_acc_err && acc_err_m == 16'h0000) begin
         acc_err_q <= 16'h0000;
      end
   end

   // Status word tracks the drive every cycle; bus writes to it are ignored.
   always_ff @(posedge aclk) begin
      if (!aresetn) status_q <= dcs_pkg::RST_WORD;
      else          status_q <= drive_status_in;
   end

   // User alarm, decimal select and monitor words.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         alarm_q   <= dcs_pkg::RST_WORD;
         dec_sel_q <= dcs_pkg::RST_WORD;
         mon_q[0]  <= dcs_pkg::RST_WORD;
         mon_q[1]  <= dcs_pkg::RST_WORD;
         mon_q[2]  <= dcs_pkg::RST_WORD;
      end else if (do_wr) begin
         if (sel_alarm)   alarm_q   <= merge(alarm_q);
         if (sel_dec_sel) dec_sel_q <= merge(dec_sel_q);
         if (sel_mon1)    mon_q[0]  <= merge(mon_q[0]);
         if (sel_mon2)    mon_q[1]  <= merge(mon_q[1]);
         if (sel_mon3)    mon_q[2]  <= merge(mon_q[2]);
      end
   end

   // Mode decode; run control from registers only counts outside panel mode.
   wire net_mode   = op_mode == dcs_pkg::MODE_NET;
   wire panel_mode = op_mode == dcs_pkg::MODE_PANEL;

   wire [N-1:0]   route_level;
   wire [N*8-1:0] route_func;

   dcs_input_route #(
      .N (N)
   ) u_route (
      .run_cmd     (run_cmd_q),
      .run_flags   (run_command_flags),
      .run_ena     (run_ena_q),
      .term_in     (term_in),
      .bus_in      (bus_in),
      .func_assign (input_function_assignment),
      .net_mode    (net_mode),
      .panel_mode  (panel_mode),
      .level       (route_level),
      .func        (route_func)
   );

   // Alarm valid only inside the window and with the sequence function on.
   wire alarm_in_win = alarm_q >= dcs_pkg::ALARM_MIN && alarm_q <= dcs_pkg::ALARM_MAX;
   wire alarm_on     = alarm_in_win && sequence_function_enable_param != 8'h00;

   // Panel monitor selection; only the three defined decimal fields are looked at.
   wire sel_m1 = monitor_display_selection == dcs_pkg::DISP_MON1;
   wire sel_m2 = monitor_display_selection == dcs_pkg::DISP_MON2;
   wire sel_m3 = monitor_display_selection == dcs_pkg::DISP_MON3;
   wire [15:0] mon_pick = sel_m1 ? mon_q[0] : sel_m2 ? mon_q[1] : sel_m3 ? mon_q[2] : 16'h0000;
   wire [1:0]  dp_pick  = sel_m1 ? dec_sel_q[dcs_pkg::DP_POS_MON1 +: 2] :
                          sel_m2 ? dec_sel_q[dcs_pkg::DP_POS_MON2 +: 2] :
                          sel_m3 ? dec_sel_q[dcs_pkg::DP_POS_MON3 +: 2] : 2'b00;

   // Drive-side outputs are registered so the drive sees clean levels.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         level_q      <= '0;
         func_q       <= '0;
         seq_q        <= 1'b0;
         alarm_out_q  <= 1'b0;
         alarm_code_q <= 5'h00;
         mon_valid_q  <= 1'b0;
         mon_value_q  <= 16'h0000;
         mon_dp_q     <= 2'b00;
      end else begin
         level_q      <= route_level;
         func_q       <= route_func;
         seq_q        <= sequence_start_input;
         alarm_out_q  <= alarm_on;
         alarm_code_q <= alarm_on ? alarm_q[4:0] : 5'h00;
         mon_valid_q  <= sel_m1 | sel_m2 | sel_m3;
         mon_value_q  <= mon_pick;
         mon_dp_q     <= dp_pick;
      end
   end

   // Port drive.
   assign awready         = awready_q;
   assign wready          = wready_q;
   assign bvalid          = bvalid_q;
   assign bresp           = bresp_q;
   assign arready         = arready_q;
   assign rvalid          = rvalid_q;
   assign rdata           = rdata_q;
   assign rresp           = rresp_q;
   assign drive_in_level  = level_q;
   assign drive_in_func   = func_q;
   assign drive_seq_start = seq_q;
   assign user_alarm      = alarm_out_q;
   assign user_alarm_code = alarm_code_q;
   assign panel_mon_valid = mon_valid_q;
   assign panel_mon_value = mon_value_q;
   assign panel_mon_dp    = mon_dp_q;
endmodule : dcs_regs
`default_nettype wire

// File: bench/dcs_regs_chk.sv
// Checker for the drive side outputs of the register bank, bound to its top module.
`timescale 1ns/10ps
`default_nettype none
module dcs_regs_chk #(
   parameter int N = 12
) (
   input wire logic           aclk,
   input wire logic           aresetn,
   input wire logic [1:0]     op_mode,
   input wire logic [N-1:0]   term_in,
   input wire logic [N-1:0]   bus_in,
   input wire logic           sequence_start_input,
   input wire logic [7:0]     sequence_function_enable_param,
   input wire logic [7:0]     monitor_display_selection,
   input wire logic [N-1:0]   drive_in_level,
   input wire logic [N*8-1:0] drive_in_func,
   input wire logic           drive_seq_start,
   input wire logic           user_alarm,
   input wire logic [4:0]     user_alarm_code,
   input wire logic           panel_mon_valid,
   input wire logic [15:0]    panel_mon_value,
   input wire logic [1:0]     panel_mon_dp
);
   // One clock domain, so clocking and reset are given once here.
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   // A monitor reaches the panel only for the three user display codes.
   wire logic mon_sel;
   assign mon_sel = monitor_display_selection inside
      {dcs_pkg::DISP_MON1, dcs_pkg::DISP_MON2, dcs_pkg::DISP_MON3};

   // A one-cycle start pulse at the terminals and the same pulse at the drive output, matched one cycle later.
   sequence s_start_in;
      sequence_start_input ##1 !sequence_start_input;
   endsequence
   sequence s_start_out;
      drive_seq_start ##1 !drive_seq_start;
   endsequence

   // Most checks tie a registered output to the inputs of the cycle before, the start copy too; the two alarm code checks look at one cycle.
   a_seq_start_copy: assert property (s_start_in |-> s_start_out)
      else $error("sequence start not taken from the terminal");
   a_panel_terminal_only: assert property (op_mode == dcs_pkg::MODE_PANEL |=>
      drive_in_level == ($past(term_in) | $past(bus_in)))
      else $error("register control active in panel mode");
   a_net_fwd_rev: assert property (op_mode == dcs_pkg::MODE_NET |=>
      drive_in_func[15:0] == {dcs_pkg::FUNC_REVERSE, dcs_pkg::FUNC_FORWARD})
      else $error("first two positions not forward and reverse in network mode");
   a_alarm_disabled: assert property (sequence_function_enable_param == 8'h00 |=> !user_alarm)
      else $error("alarm raised while the sequence function is off");
   a_alarm_code_range: assert property (user_alarm |-> user_alarm_code inside {[5'h10:5'h14]})
      else $error("alarm code outside the user range");
   a_alarm_code_idle: assert property (!user_alarm |-> user_alarm_code == 5'h00)
      else $error("alarm code shown without an alarm");
   a_monitor_shown: assert property (mon_sel |=> panel_mon_valid)
      else $error("user monitor not shown");
   a_monitor_blank: assert property (!mon_sel |=> !panel_mon_valid && panel_mon_value == 16'h0000
      && panel_mon_dp == 2'h0)
      else $error("panel monitor not blank");
endmodule : dcs_regs_chk

bind dcs_regs dcs_regs_chk #(.N(N)) u_dcs_chk (
   .aclk, .aresetn, .op_mode, .term_in, .bus_in, .sequence_start_input,
   .sequence_function_enable_param, .monitor_display_selection, .drive_in_level,
   .drive_in_func, .drive_seq_start, .user_alarm, .user_alarm_code, .panel_mon_valid,
   .panel_mon_value, .panel_mon_dp
);
`default_nettype wire

// File: bench/tb.sv
// Self-checking bench for the drive command and status register bank.
`timescale 1ns/10ps
`default_nettype none
module tb;
   logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
   logic        arvalid, arready, rvalid, rready, seq_in, seq_out, perr, oerr, alarm, mon_valid;
   logic [1:0]  bresp, rresp, op_mode, mon_dp;
   logic [4:0]  alarm_code;
   logic [7:0]  awaddr, araddr, seq_en, disp_sel;
   logic [11:0] flags, term_in, bus_in, level;
   logic [14:0] perr_num;
   logic [15:0] status_in, mon_value;
   logic [31:0] wdata, rdata;
   logic [95:0] func_asg, func;
   int          error_cnt = 0;
   int          checks_done = 0;
   logic [1:0]  dp_exp [3] = '{2'h1, 2'h0, 2'h3};
   int          av [6] = '{15, 16, 18, 20, 21, 48};

   dcs_regs #(.N(12), .AW(8)) DUT (
      .aclk, .aresetn, .awaddr, .awprot(3'h0), .awvalid, .awready, .wdata, .wstrb(4'hf), .wvalid,
      .wready, .bresp, .bvalid, .bready, .araddr, .arprot(3'h0), .arvalid, .arready, .rdata, .rresp,
      .rvalid, .rready, .op_mode, .run_command_flags(flags), .term_in, .bus_in,
      .input_function_assignment(func_asg), .sequence_start_input(seq_in), .drive_status_in(status_in),
      .param_err_pulse(perr), .param_err_num(perr_num), .other_err_pulse(oerr),
      .sequence_function_enable_param(seq_en), .monitor_display_selection(disp_sel),
      .drive_in_level(level), .drive_in_func(func), .drive_seq_start(seq_out), .user_alarm(alarm),
      .user_alarm_code(alarm_code), .panel_mon_valid(mon_valid), .panel_mon_value(mon_value),
      .panel_mon_dp(mon_dp)
   );

   // Free-running 25 MHz clock.
   initial begin
      aclk = 1'b0;
      forever #20 aclk = ~aclk;
   end

   // Count one comparison and report a mismatch at once.
   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      checks_done++;
      if (got !== exp) begin
         error_cnt++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
      end
   endtask : chk

   // Print the counts and the verdict, then end the run.
   task automatic report_and_stop();
      $display("checks %0d errors %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : report_and_stop

   task automatic tick(input int n);
      repeat (n) @(posedge aclk);
   endtask : tick

   // Write one word; address and data are offered together and each is released once taken.
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      int n;
      n = 0;
      @(posedge aclk);
      awaddr  <= a;
      wdata   <= d;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      do begin
         @(posedge aclk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         n++;
      end while (!bvalid && n < 100);
      chk("bvalid", 1'b1, bvalid);
      chk("bresp", er, bresp);
      bready <= 1'b0;
   endtask : wr

   // Read one word and compare data and response at the handshake edge.
   task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
      int n;
      n = 0;
      @(posedge aclk);
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      do begin
         @(posedge aclk);
         if (arvalid && arready) arvalid <= 1'b0;
         n++;
      end while (!rvalid && n < 100);
      chk("rvalid", 1'b1, rvalid);
      chk("rdata", ed, rdata);
      chk("rresp", er, rresp);
      rready <= 1'b0;
   endtask : rd

   // Watchdog ends the run after 5000 cycles; each handshake wait already gives up after 100 cycles.
   initial begin
      repeat (5000) @(posedge aclk);
      error_cnt++;
      report_and_stop();
   end

   // Main sequence of register accesses and drive side checks.
   initial begin
      {aresetn, awvalid, wvalid, bready, arvalid, rready, seq_in, perr, oerr} = '0;
      {awaddr, araddr, wdata, flags, term_in, bus_in, perr_num, seq_en, disp_sel} = '0;
      op_mode = dcs_pkg::MODE_EXT;
      func_asg = {12{8'h07}};
      status_in = 16'h5a3c;
      repeat (8) @(posedge aclk);
      aresetn <= 1'b1;
      rd(dcs_pkg::OFS_RUN_CMD, 32'h0, dcs_pkg::RESP_OKAY);
      rd(dcs_pkg::OFS_RUN_ENA, 32'h0, dcs_pkg::RESP_OKAY);
      rd(dcs_pkg::OFS_ACC_ERR, 32'h0, dcs_pkg::RESP_OKAY);
      rd(dcs_pkg::OFS_STATUS, 32'h5a3c, dcs_pkg::RESP_OKAY);
      status_in <= 16'h00c3;
      wr(dcs_pkg::OFS_STATUS, 32'hffff, dcs_pkg::RESP_OKAY);
      rd(dcs_pkg::OFS_STATUS, 32'h00c3, dcs_pkg::RESP_OKAY);
      // The select flag has no pin on this block; the bench counts it as set from here on.
      term_in <= 12'hfff;
      wr(dcs_pkg::OFS_RUN_CMD, 32'hffff_ffff, dcs_pkg::RESP_OKAY);
      rd(dcs_pkg::OFS_RUN_CMD, 32'h0fff, dcs_pkg::RESP_OKAY);
      wr(dcs_pkg::OFS_RUN_CMD, 32'h5, dcs_pkg::RESP_OKAY);
      wr(dcs_pkg::OFS_RUN_ENA, 32'hfff, dcs_pkg::RESP_OKAY);
      tick(2);
      chk("level", 12'h005, level);
      // Only position 0 is handed over; the flag at position 6 has no say there.
      term_in <= 12'h0a0;
      bus_in <= 12'h300;
      flags <= 12'h040;
      wr(dcs_pkg::OFS_RUN_ENA, 32'h1, dcs_pkg::RESP_OKAY);
      tick(2);
      chk("level", 12'h3a1, level);
      op_mode <= dcs_pkg::MODE_PANEL;
      tick(2);
      chk("level", 12'h3a0, level);
      rd(dcs_pkg::OFS_RUN_CMD, 32'h5, dcs_pkg::RESP_OKAY);
      // A handed-over position assigned the start function must lose it.
      op_mode <= dcs_pkg::MODE_EXT;
      func_asg <= {{8{8'h07}}, dcs_pkg::FUNC_SEQ_START, {3{8'h07}}};
      wr(dcs_pkg::OFS_RUN_ENA, 32'h9, dcs_pkg::RESP_OKAY);
      seq_in <= 1'b1;
      tick(2);
      seq_in <= 1'b0;
      chk("func3", dcs_pkg::FUNC_NONE, func[31:24]);
      chk("func0", 8'h07, func[7:0]);
      op_mode <= dcs_pkg::MODE_NET;
      tick(2);
      chk("func01", {dcs_pkg::FUNC_REVERSE, dcs_pkg::FUNC_FORWARD}, func[15:0]);
      // Error codes stick until a zero is written.
      perr_num <= 15'd10;
      perr <= 1'b1;
      tick(1);
      perr <= 1'b0;
      rd(dcs_pkg::OFS_ACC_ERR, dcs_pkg::ERR_PARAM_BASE | 16'd10, dcs_pkg::RESP_OKAY);
      wr(dcs_pkg::OFS_ACC_ERR, 32'h1234, dcs_pkg::RESP_OKAY);
      rd(dcs_pkg::OFS_ACC_ERR, dcs_pkg::ERR_PARAM_BASE | 16'd10, dcs_pkg::RESP_OKAY);
      wr(dcs_pkg::OFS_ACC_ERR, 32'h0, dcs_pkg::RESP_OKAY);
      rd(dcs_pkg::OFS_ACC_ERR, 32'h0, dcs_pkg::RESP_OKAY);
      oerr <= 1'b1;
      tick(1);
      oerr <= 1'b0;
      rd(dcs_pkg::OFS_ACC_ERR, dcs_pkg::ERR_OTHER, dcs_pkg::RESP_OKAY);
      // Alarm values at and beyond both edges of the valid window.
      seq_en <= 8'h01;
      foreach (av[i]) begin
         wr(dcs_pkg::OFS_ALARM, av[i], dcs_pkg::RESP_OKAY);
         tick(2);
         chk("alarm", av[i] >= 16 && av[i] <= 20, alarm);
         chk("alarm_code", (av[i] >= 16 && av[i] <= 20) ? av[i] : 0, alarm_code);
      end
      wr(dcs_pkg::OFS_ALARM, 32'h10, dcs_pkg::RESP_OKAY);
      seq_en <= 8'h00;
      tick(2);
      chk("alarm", 1'b0, alarm);
      // Stray bits set around the decimal fields must not matter.
      wr(dcs_pkg::OFS_DEC_SEL, 32'hf1ff, dcs_pkg::RESP_OKAY);
      for (int i = 0; i < 3; i++) wr(dcs_pkg::OFS_MON1 + 8'(4 * i), 32'h1111 * (i + 1), dcs_pkg::RESP_OKAY);
      for (int i = 0; i < 3; i++) begin
         disp_sel <= dcs_pkg::DISP_MON1 + 8'(i);
         tick(2);
         chk("mon_valid", 1'b1, mon_valid);
         chk("mon_value", 32'h1111 * (i + 1), mon_value);
         chk("mon_dp", dp_exp[i], mon_dp);
      end
      disp_sel <= 8'h00;
      tick(2);
      chk("mon_valid", 1'b0, mon_valid);
      wr(8'h24, 32'h1, dcs_pkg::RESP_SLVERR);
      rd(8'h24, 32'h0, dcs_pkg::RESP_SLVERR);
      report_and_stop();
   end
endmodule : tb
`default_nettype wire
